// >>> rtl/aspc_pkg.sv
/*
  Constants for the asynchronous serial port: register addresses, field
  positions, reset values, modes, baud sources and bit-timing counts.
  Assumes the special function register bus of an 8-bit processor core.
*/
package aspc_pkg;

  localparam logic [7:0] ADDR_STATUS  = 8'h91;
  localparam logic [7:0] ADDR_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_BUFFER  = 8'h99;
  localparam logic [7:0] ADDR_SADDR   = 8'ha9;
  localparam logic [7:0] ADDR_SMASK   = 8'hb9;

  localparam logic [7:0] RST_STATUS  = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_BUFFER  = 8'h00;
  localparam logic [7:0] RST_SADDR   = 8'h00;
  localparam logic [7:0] RST_SMASK   = 8'h00;

  // Control register fields
  localparam int CTL_MODE_HI = 7;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_MP_EN   = 5;
  localparam int CTL_RX_EN   = 4;
  localparam int CTL_TB8     = 3;
  localparam int CTL_RB8     = 2;
  localparam int CTL_TI      = 1;
  localparam int CTL_RI      = 0;

  // Status and clock select fields
  localparam int STA_FE      = 7;
  localparam int STA_RXOV    = 6;
  localparam int STA_TXCOL   = 5;
  localparam int STA_DOUBLER = 4;
  localparam int STA_TXSRC   = 2;
  localparam int STA_RXSRC   = 0;

  typedef enum logic [1:0] {
    ASPC_MODE_SYNC  = 2'b00,
    ASPC_MODE_8VAR  = 2'b01,
    ASPC_MODE_9FIX  = 2'b10,
    ASPC_MODE_9VAR  = 2'b11
  } aspc_mode_t;

  typedef enum logic [1:0] {
    ASPC_SRC_T1 = 2'b00,
    ASPC_SRC_T2 = 2'b01,
    ASPC_SRC_T3 = 2'b10,
    ASPC_SRC_T4 = 2'b11
  } aspc_src_t;

  // Sixteen oversampling ticks per bit
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID  = 4'h7;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  // Fixed mode: sysclk/64 is a tick every 4 clocks, sysclk/32 every 2
  localparam logic [1:0] FIX_DIV_SLOW = 2'h3;
  localparam logic [1:0] FIX_DIV_FAST = 2'h1;

  // Reference point of the timer one source
  localparam int REF_SYSCLK_HZ = 22118400;
  localparam logic [7:0] REF_T1_RELOAD = 8'hf4;
  localparam int REF_BAUD = 115200;

endpackage : aspc_pkg

// >>> rtl/aspc_uart.sv
/*
  Control, status, data buffer and slave-address logic of the asynchronous
  serial port, with its transmitter and receiver.
  Assumes a single-clock register bus with one-cycle strobes, and timer
  overflow pulses from timers on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module aspc_uart (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       timer1_ovf,
  input  wire logic       timer2_ovf,
  input  wire logic       timer3_ovf,
  input  wire logic       timer4_ovf,
  input  wire logic       rx_pin,
  output logic            tx_pin,
  output logic            serial_irq
);

  typedef enum logic [4:0] {
    ASPC_IDLE  = 5'b00001,
    ASPC_START = 5'b00010,
    ASPC_DATA  = 5'b00100,
    ASPC_NINTH = 5'b01000,
    ASPC_STOP  = 5'b10000
  } aspc_state_t;

  logic [7:0]  ctl_q;
  logic [7:0]  sta_q;
  logic [7:0]  saddr_q;
  logic [7:0]  smask_q;
  logic [7:0]  rxbuf_q;
  logic [7:0]  txbuf_q;
  logic [7:0]  rdata_q;
  logic        unread_q;
  logic        rx_meta_q;
  logic        rx_sync_q;
  logic        t1_half_q;
  logic [1:0]  fix_cnt_q;
  logic        tx_q;
  aspc_state_t tx_state_q;
  logic [3:0]  tx_tick_q;
  logic [2:0]  tx_bit_q;
  aspc_state_t rx_state_q;
  logic [3:0]  rx_tick_q;
  logic [2:0]  rx_bit_q;
  logic [7:0]  rx_shift_q;
  logic        rx_ninth_q;
  logic        rx_armed_q;

  aspc_pkg::aspc_mode_t mode;
  logic       nine_bit;
  logic       wr_ctl;
  logic       wr_sta;
  logic       wr_buf;
  logic       rd_buf;
  logic       t1_tick;
  logic       fix_tick;
  logic       tx_tick;
  logic       rx_tick;
  logic       tx_busy;
  logic       tx_load;
  logic       tx_enter_stop;
  logic       rx_done;
  logic       stop_bit;
  logic       masked_hit;
  logic       bcast_hit;
  logic       accept;
  logic [7:0] bcast_addr;

  assign mode     = aspc_pkg::aspc_mode_t'(ctl_q[aspc_pkg::CTL_MODE_HI:
                                                 aspc_pkg::CTL_MODE_LO]);
  assign nine_bit = ctl_q[aspc_pkg::CTL_MODE_HI];
  assign wr_ctl   = sfr_wr && (sfr_addr == aspc_pkg::ADDR_CONTROL);
  assign wr_sta   = sfr_wr && (sfr_addr == aspc_pkg::ADDR_STATUS);
  assign wr_buf   = sfr_wr && (sfr_addr == aspc_pkg::ADDR_BUFFER);
  assign rd_buf   = sfr_rd && (sfr_addr == aspc_pkg::ADDR_BUFFER);
  assign tx_busy  = (tx_state_q != ASPC_IDLE);
  assign tx_load  = wr_buf && !tx_busy
                    && (mode != aspc_pkg::ASPC_MODE_SYNC);

  // Pin synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= rx_pin;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Timer one overflow halved unless the doubler bypasses it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t1_half_q <= 1'b0;
    end else if (timer1_ovf) begin
      t1_half_q <= ~t1_half_q;
    end
  end
  assign t1_tick = timer1_ovf
                   && (sta_q[aspc_pkg::STA_DOUBLER] || t1_half_q);

  // Fixed-rate divider for the fixed 9-bit mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fix_cnt_q <= 2'h0;
    end else if (fix_tick) begin
      fix_cnt_q <= 2'h0;
    end else begin
      fix_cnt_q <= fix_cnt_q + 2'h1;
    end
  end
  assign fix_tick = (fix_cnt_q == (sta_q[aspc_pkg::STA_DOUBLER] ?
                     aspc_pkg::FIX_DIV_FAST : aspc_pkg::FIX_DIV_SLOW));

  // Oversampling tick source per direction
  always_comb begin
    tx_tick = 1'b0;
    rx_tick = 1'b0;
    if (mode == aspc_pkg::ASPC_MODE_9FIX) begin
      tx_tick = fix_tick;
      rx_tick = fix_tick;
    end else begin
      case (aspc_pkg::aspc_src_t'(sta_q[aspc_pkg::STA_TXSRC +: 2]))
        aspc_pkg::ASPC_SRC_T1: tx_tick = t1_tick;
        aspc_pkg::ASPC_SRC_T2: tx_tick = timer2_ovf;
        aspc_pkg::ASPC_SRC_T3: tx_tick = timer3_ovf;
        aspc_pkg::ASPC_SRC_T4: tx_tick = timer4_ovf;
        default:               tx_tick = 1'b0;
      endcase
      case (aspc_pkg::aspc_src_t'(sta_q[aspc_pkg::STA_RXSRC +: 2]))
        aspc_pkg::ASPC_SRC_T1: rx_tick = t1_tick;
        aspc_pkg::ASPC_SRC_T2: rx_tick = timer2_ovf;
        aspc_pkg::ASPC_SRC_T3: rx_tick = timer3_ovf;
        aspc_pkg::ASPC_SRC_T4: rx_tick = timer4_ovf;
        default:               rx_tick = 1'b0;
      endcase
    end
  end

  // Transmitter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state_q <= ASPC_IDLE;
      tx_tick_q  <= 4'h0;
      tx_bit_q   <= 3'h0;
      txbuf_q    <= aspc_pkg::RST_BUFFER;
      tx_q       <= 1'b1;
    end else begin
      case (tx_state_q)
        ASPC_IDLE: begin
          tx_q <= 1'b1;
          if (tx_load) begin
            txbuf_q    <= sfr_wdata;
            tx_tick_q  <= 4'h0;
            tx_bit_q   <= 3'h0;
            tx_q       <= 1'b0;
            tx_state_q <= ASPC_START;
          end
        end
        ASPC_START: begin
          if (tx_tick) begin
            tx_tick_q <= tx_tick_q + 4'h1;
            if (tx_tick_q == aspc_pkg::TICK_LAST) begin
              tx_q       <= txbuf_q[0];
              tx_state_q <= ASPC_DATA;
            end
          end
        end
        ASPC_DATA: begin
          if (tx_tick) begin
            tx_tick_q <= tx_tick_q + 4'h1;
            if (tx_tick_q == aspc_pkg::TICK_LAST) begin
              tx_bit_q <= tx_bit_q + 3'h1;
              txbuf_q  <= {1'b0, txbuf_q[7:1]};
              if (tx_bit_q != aspc_pkg::BIT_LAST) begin
                tx_q <= txbuf_q[1];
              end else if (nine_bit) begin
                tx_q       <= ctl_q[aspc_pkg::CTL_TB8];
                tx_state_q <= ASPC_NINTH;
              end else begin
                tx_q       <= 1'b1;
                tx_state_q <= ASPC_STOP;
              end
            end
          end
        end
        ASPC_NINTH: begin
          if (tx_tick) begin
            tx_tick_q <= tx_tick_q + 4'h1;
            if (tx_tick_q == aspc_pkg::TICK_LAST) begin
              tx_q       <= 1'b1;
              tx_state_q <= ASPC_STOP;
            end
          end
        end
        ASPC_STOP: begin
          if (tx_tick) begin
            tx_tick_q <= tx_tick_q + 4'h1;
            if (tx_tick_q == aspc_pkg::TICK_LAST) begin
              tx_state_q <= ASPC_IDLE;
            end
          end
        end
        default: begin
          tx_state_q <= ASPC_IDLE;
          tx_q       <= 1'b1;
        end
      endcase
    end
  end
  assign tx_enter_stop = tx_tick && (tx_tick_q == aspc_pkg::TICK_LAST)
                         && ((tx_state_q == ASPC_NINTH)
                         || ((tx_state_q == ASPC_DATA) && !nine_bit
                         && (tx_bit_q == aspc_pkg::BIT_LAST)));

  // Receiver, sampling mid-bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state_q <= ASPC_IDLE;
      rx_tick_q  <= 4'h0;
      rx_bit_q   <= 3'h0;
      rx_shift_q <= 8'h00;
      rx_ninth_q <= 1'b0;
      rx_armed_q <= 1'b1;
    end else begin
      if (rx_tick) begin
        rx_tick_q <= rx_tick_q + 4'h1;
      end
      // Start taken only after the line has been high again
      if (rx_sync_q) begin
        rx_armed_q <= 1'b1;
      end else if (rx_state_q != ASPC_IDLE) begin
        rx_armed_q <= 1'b0;
      end
      case (rx_state_q)
        ASPC_IDLE: begin
          rx_tick_q <= 4'h0;
          rx_bit_q  <= 3'h0;
          if (rx_tick && !rx_sync_q && rx_armed_q
              && ctl_q[aspc_pkg::CTL_RX_EN]
              && (mode != aspc_pkg::ASPC_MODE_SYNC)) begin
            rx_tick_q  <= 4'h1;
            rx_state_q <= ASPC_START;
          end
        end
        ASPC_START: begin
          if (rx_tick && (rx_tick_q == aspc_pkg::TICK_MID) && rx_sync_q) begin
            rx_state_q <= ASPC_IDLE;
          end else if (rx_tick && (rx_tick_q == aspc_pkg::TICK_LAST)) begin
            rx_state_q <= ASPC_DATA;
          end
        end
        ASPC_DATA: begin
          if (rx_tick && (rx_tick_q == aspc_pkg::TICK_MID)) begin
            rx_shift_q <= {rx_sync_q, rx_shift_q[7:1]};
          end
          if (rx_tick && (rx_tick_q == aspc_pkg::TICK_LAST)) begin
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == aspc_pkg::BIT_LAST) begin
              rx_state_q <= nine_bit ? ASPC_NINTH : ASPC_STOP;
            end
          end
        end
        ASPC_NINTH: begin
          if (rx_tick && (rx_tick_q == aspc_pkg::TICK_MID)) begin
            rx_ninth_q <= rx_sync_q;
          end
          if (rx_tick && (rx_tick_q == aspc_pkg::TICK_LAST)) begin
            rx_state_q <= ASPC_STOP;
          end
        end
        ASPC_STOP: begin
          if (rx_done) begin
            rx_state_q <= ASPC_IDLE;
          end
        end
        default: rx_state_q <= ASPC_IDLE;
      endcase
    end
  end
  assign rx_done  = (rx_state_q == ASPC_STOP) && rx_tick
                    && (rx_tick_q == aspc_pkg::TICK_MID);
  assign stop_bit = rx_sync_q;

  // Address recognition
  assign masked_hit = ((rx_shift_q ^ saddr_q) & smask_q) == 8'h00;
  assign bcast_addr = saddr_q | smask_q;
  assign bcast_hit  = (rx_shift_q & bcast_addr) == bcast_addr;

  always_comb begin
    accept = 1'b1;
    if (ctl_q[aspc_pkg::CTL_MP_EN]) begin
      if (nine_bit) begin
        accept = rx_ninth_q && (masked_hit || bcast_hit);
      end else begin
        accept = stop_bit;
      end
    end
  end

  // Receive buffer and unread tracking
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxbuf_q  <= aspc_pkg::RST_BUFFER;
      unread_q <= 1'b0;
    end else begin
      if (rx_done && accept) begin
        rxbuf_q  <= rx_shift_q;
        unread_q <= 1'b1;
      end else if (rd_buf) begin
        unread_q <= 1'b0;
      end
    end
  end

  // Control register; hardware sets win over software clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_q <= aspc_pkg::RST_CONTROL;
    end else begin
      if (wr_ctl) begin
        ctl_q <= sfr_wdata;
      end
      if (tx_enter_stop) begin
        ctl_q[aspc_pkg::CTL_TI] <= 1'b1;
      end
      if (rx_done && accept) begin
        ctl_q[aspc_pkg::CTL_RI]  <= 1'b1;
        ctl_q[aspc_pkg::CTL_RB8] <= nine_bit ? rx_ninth_q : stop_bit;
      end
    end
  end

  // Status and clock select register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sta_q <= aspc_pkg::RST_STATUS;
    end else begin
      if (wr_sta) begin
        sta_q <= sfr_wdata;
      end
      if (rx_done && !stop_bit) begin
        sta_q[aspc_pkg::STA_FE] <= 1'b1;
      end
      if (rx_done && accept && unread_q) begin
        sta_q[aspc_pkg::STA_RXOV] <= 1'b1;
      end
      if (wr_buf && tx_busy) begin
        sta_q[aspc_pkg::STA_TXCOL] <= 1'b1;
      end
    end
  end

  // Address and mask registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      saddr_q <= aspc_pkg::RST_SADDR;
      smask_q <= aspc_pkg::RST_SMASK;
    end else begin
      if (sfr_wr && (sfr_addr == aspc_pkg::ADDR_SADDR)) begin
        saddr_q <= sfr_wdata;
      end
      if (sfr_wr && (sfr_addr == aspc_pkg::ADDR_SMASK)) begin
        smask_q <= sfr_wdata;
      end
    end
  end

  // Registered read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        aspc_pkg::ADDR_CONTROL: rdata_q <= ctl_q;
        aspc_pkg::ADDR_STATUS:  rdata_q <= sta_q;
        aspc_pkg::ADDR_BUFFER:  rdata_q <= rxbuf_q;
        aspc_pkg::ADDR_SADDR:   rdata_q <= saddr_q;
        aspc_pkg::ADDR_SMASK:   rdata_q <= smask_q;
        default:                rdata_q <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata  = rdata_q;
  assign tx_pin     = tx_q;
  assign serial_irq = ctl_q[aspc_pkg::CTL_TI]
                      || ctl_q[aspc_pkg::CTL_RI];

endmodule : aspc_uart
`default_nettype wire

// >>> testbench/aspc_uart_monitor.sv
/*
  Checker on the serial port's top-level ports.
  Assumes bind into aspc_uart and buffer loads after 1023 idle line clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module aspc_uart_monitor (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       tx_pin,
  input wire logic       serial_irq
);
  logic [7:0] ctl_q;
  logic [7:0] sta_q;
  logic [7:0] adr_q;
  logic [9:0] high_q;
  logic       mapped;

  assign mapped = sfr_addr inside {aspc_pkg::ADDR_STATUS,
    aspc_pkg::ADDR_CONTROL, aspc_pkg::ADDR_BUFFER, aspc_pkg::ADDR_SADDR,
    aspc_pkg::ADDR_SMASK};

  // Shadow of software-owned bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_q <= 8'h00;
      sta_q <= 8'h00;
      adr_q <= 8'h00;
    end else if (sfr_wr) begin
      if (sfr_addr == aspc_pkg::ADDR_CONTROL) ctl_q <= sfr_wdata;
      if (sfr_addr == aspc_pkg::ADDR_STATUS) sta_q <= sfr_wdata;
      if (sfr_addr == aspc_pkg::ADDR_SADDR) adr_q <= sfr_wdata;
    end
  end

  // Clocks the line has stayed high, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) high_q <= 10'h000;
    else if (!tx_pin) high_q <= 10'h000;
    else if (high_q != 10'h3ff) high_q <= high_q + 10'h001;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_idle_load;
    sfr_wr && sfr_addr == aspc_pkg::ADDR_BUFFER && high_q == 10'h3ff
      && ctl_q[7:6] != 2'b00;
  endsequence
  sequence s_start_bit;
    !tx_pin [*8];
  endsequence

  a_tx_start: assert property (s_idle_load |=> s_start_bit)
    else $error("start bit did not follow a buffer load");
  a_flag_sticky: assert property (serial_irq
    && !(sfr_wr && sfr_addr == aspc_pkg::ADDR_CONTROL) |=> serial_irq)
    else $error("interrupt dropped without a control write");
  a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (sfr_rd && !mapped |=> sfr_rdata == 0)
    else $error("unmapped read not zero");
  a_mode_readback: assert property (sfr_rd
    && sfr_addr == aspc_pkg::ADDR_CONTROL |=> ((sfr_rdata ^ ctl_q) & 8'hf8)
    == 8'h00) else $error("control bits differ from written value");
  a_clock_readback: assert property (sfr_rd
    && sfr_addr == aspc_pkg::ADDR_STATUS |=> ((sfr_rdata ^ sta_q) & 8'h1f)
    == 8'h00) else $error("clock select bits differ from written value");
  a_addr_readback: assert property (sfr_rd
    && sfr_addr == aspc_pkg::ADDR_SADDR |=> sfr_rdata == adr_q)
    else $error("slave address differs from written value");
  a_reset_idle: assert property ($fell(rst) |-> tx_pin && !serial_irq)
    else $error("line or interrupt not idle after reset");
endmodule : aspc_uart_monitor

bind aspc_uart aspc_uart_monitor mon (
  .clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .tx_pin,
  .serial_irq
);
`default_nettype wire

// >>> testbench/aspc_uart_station.sv
/*
  Remote serial station: sends frames on the receive line and decodes
  frames from the transmit line. Assumes the bench sets bit length and size.
*/
`timescale 1ns/1ps
`default_nettype none
module aspc_uart_station (
  input  wire logic clk,
  input  wire logic tx_pin,
  output var  logic rx_pin
);
  int         bit_cyc;
  logic       nine;
  int         frames;
  int         start_len;
  logic [9:0] got;
  logic [7:0] rx_d;
  logic       rx_n9;

  initial begin
    rx_pin  = 1'b1;
    bit_cyc = 32;
    nine    = 1'b0;
    frames  = 0;
  end

  // Start, data LSB first, optional ninth bit, stop
  task automatic send(input logic [7:0] d, input logic n9, input logic stp);
    logic [10:0] fr;
    fr = nine ? {stp, n9, d, 1'b0} : {1'b1, stp, d, 1'b0};
    @(posedge clk);
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      rx_pin <= fr[i];
      repeat (bit_cyc) @(posedge clk);
    end
    rx_pin <= 1'b1;
    @(posedge clk);
  endtask : send

  // Samples mid-bit on the falling clock edge
  always begin
    @(negedge tx_pin);
    start_len = 0;
    for (int c = 1; c < bit_cyc * (nine ? 11 : 10); c++) begin
      @(negedge clk);
      if (tx_pin && start_len == 0) start_len = c - 1;
      if (c >= bit_cyc && c % bit_cyc == bit_cyc / 2) got = {tx_pin, got[9:1]};
    end
    rx_d  = nine ? got[7:0] : got[8:1];
    rx_n9 = got[8];
    frames++;
  end
endmodule : aspc_uart_station
`default_nettype wire

// >>> testbench/aspc_uart_test.sv
/*
  Self-checking bench: registers, transmit and receive through the station
  model, address filtering. Assumes the checker binds itself to the design.
*/
`timescale 1ns/1ps
`default_nettype none
module aspc_uart_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  sfr_addr = 8'h00;
  logic        sfr_wr = 1'b0;
  logic        sfr_rd = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic [3:0]  tmr_ovf = 4'h0;
  logic        rx_pin;
  logic        tx_pin;
  logic        serial_irq;
  int          tmr_cnt = 0;
  int          t1_per = 2;
  int          err_count = 0;
  int          check_count = 0;
  int          seed = 32'he787;
  logic        dbl = 1'b1;
  logic [1:0]  rsrc = 2'b00;
  logic [7:0]  saddr = 8'h00;
  logic [7:0]  smask = 8'h00;
  logic [4:0]  tcfg [7] = '{5'b01100, 5'b01000, 5'b01101, 5'b11110,
                            5'b11011, 5'b10100, 5'b10000};
  logic [17:0] rcase [10] = '{{8'hf0, 8'hf5, 2'b11}, {8'hf0, 8'hf5, 2'b01},
    {8'hf0, 8'h36, 2'b11}, {8'hf0, 8'hff, 2'b11}, {8'hb0, 8'hc5, 2'b11},
    {8'h70, 8'h5a, 2'b00}, {8'h70, 8'h5a, 2'b01}, {8'h50, 8'ha5, 2'b00},
    {8'hc0, 8'h11, 2'b11}, {8'hd0, 8'h3c, 2'b00}};

  always #5 clk = ~clk;

  // Timer one overflows every t1_per clocks, timer n every n+1
  always begin
    @(posedge clk);
    #1;
    tmr_cnt++;
    for (int n = 0; n < 4; n++) begin
      tmr_ovf[n] = (tmr_cnt % (n == 0 ? t1_per : n + 2) == 0);
    end
  end

  aspc_uart uut (
    .clk        (clk),
    .rst        (rst),
    .sfr_addr   (sfr_addr),
    .sfr_wr     (sfr_wr),
    .sfr_rd     (sfr_rd),
    .sfr_wdata  (sfr_wdata),
    .sfr_rdata  (sfr_rdata),
    .timer1_ovf (tmr_ovf[0]),
    .timer2_ovf (tmr_ovf[1]),
    .timer3_ovf (tmr_ovf[2]),
    .timer4_ovf (tmr_ovf[3]),
    .rx_pin     (rx_pin),
    .tx_pin     (tx_pin),
    .serial_irq (serial_irq)
  );
  aspc_uart_station st (.clk(clk), .tx_pin(tx_pin), .rx_pin(rx_pin));

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    #1;
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = w;
    sfr_rd    = !w;
    @(posedge clk);
    #1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    q      = sfr_rdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                        input logic [7:0] m, input string nm);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, e & m, q & m);
  endtask : rd_chk

  function automatic int bit_len(input logic [1:0] m, input logic db,
                                 input logic [1:0] s);
    if (m == 2'b10) return db ? 32 : 64;
    if (s == 2'b00) return (db ? 16 : 32) * t1_per;
    return 16 * (int'(s) + 2);
  endfunction : bit_len

  function automatic logic accept(input logic [1:0] m, input logic mp,
    input logic [7:0] d, input logic n9, input logic stp);
    if (!mp) return 1'b1;
    if (m == 2'b01) return stp;
    return n9 && ((((d ^ saddr) & smask) == 8'h00)
      || ((d & (saddr | smask)) == (saddr | smask)));
  endfunction : accept

  task automatic tx_case(input logic [4:0] c);
    logic [7:0] d;
    logic       n9;
    logic       ok;
    int         b;
    int         f;
    d   = 8'($random(seed)) | 8'h01;
    n9  = 1'($random(seed));
    b   = bit_len(c[4:3], c[2], c[1:0]);
    dbl = c[2];
    wr(aspc_pkg::ADDR_STATUS, {3'b000, c[2:0], rsrc});
    wr(aspc_pkg::ADDR_CONTROL, {c[4:3], 2'b00, n9, 3'b000});
    st.nine    = c[4];
    st.bit_cyc = b;
    f = st.frames;
    repeat (1100) @(posedge clk);
    wr(aspc_pkg::ADDR_BUFFER, d);
    repeat (3 * b) @(posedge clk);
    wr(aspc_pkg::ADDR_BUFFER, ~d);
    for (int i = 0; i < 16 * b && st.frames == f; i++) @(posedge clk);
    chk("tx data", d, st.rx_d);
    if (c[4]) chk("tx ninth", {7'h00, n9}, {7'h00, st.rx_n9});
    ok = st.start_len <= b + 1 && st.start_len > b - b / 16;
    chk("bit length", 8'h01, {7'h00, ok});
    rd_chk(aspc_pkg::ADDR_CONTROL, 8'h02, 8'h02, "tx flag");
    chk("irq", 8'h01, {7'h00, serial_irq});
    rd_chk(aspc_pkg::ADDR_STATUS, 8'h20, 8'h20, "collision");
    wr(aspc_pkg::ADDR_CONTROL, {c[4:3], 6'h00});
    wr(aspc_pkg::ADDR_STATUS, {3'b000, c[2:0], rsrc});
    chk("irq clear", 8'h00, {7'h00, serial_irq});
  endtask : tx_case

  task automatic rx_case(input logic [7:0] ctl, input logic [7:0] d,
                         input logic n9, input logic stp);
    logic ok;
    ok = accept(ctl[7:6], ctl[5], d, n9, stp) && ctl[4];
    wr(aspc_pkg::ADDR_CONTROL, ctl);
    st.nine    = ctl[7];
    st.bit_cyc = bit_len(ctl[7:6], dbl, rsrc);
    st.send(d, n9, stp);
    rd_chk(aspc_pkg::ADDR_CONTROL, {7'h00, ok}, 8'h01, "rx flag");
    if (ok) begin
      rd_chk(aspc_pkg::ADDR_CONTROL, {5'h00, ctl[7] ? n9 : stp, 2'b00},
             8'h04, "rx ninth");
      rd_chk(aspc_pkg::ADDR_BUFFER, d, 8'hff, "rx data");
    end
    rd_chk(aspc_pkg::ADDR_STATUS, {!stp && ctl[4], 7'h00}, 8'h80, "fe");
    wr(aspc_pkg::ADDR_STATUS, {3'b000, dbl, 2'b00, rsrc});
  endtask : rx_case

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  initial begin
    #700_000;
    err_count++;
    give_verdict();
  end

  initial begin
    logic [7:0] d;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    rd_chk(aspc_pkg::ADDR_STATUS, aspc_pkg::RST_STATUS, 8'hff, "status");
    rd_chk(aspc_pkg::ADDR_CONTROL, aspc_pkg::RST_CONTROL, 8'hff, "control");
    rd_chk(aspc_pkg::ADDR_BUFFER, aspc_pkg::RST_BUFFER, 8'hff, "buffer");
    rd_chk(aspc_pkg::ADDR_SADDR, aspc_pkg::RST_SADDR, 8'hff, "saddr");
    rd_chk(aspc_pkg::ADDR_SMASK, aspc_pkg::RST_SMASK, 8'hff, "smask");
    rd_chk(8'h55, 8'h00, 8'hff, "unmapped");
    foreach (tcfg[i]) tx_case(tcfg[i]);
    t1_per = 256 - int'(aspc_pkg::REF_T1_RELOAD);
    tx_case(5'b01100);
    chk("ref bit", 8'(aspc_pkg::REF_SYSCLK_HZ / aspc_pkg::REF_BAUD),
        8'(st.bit_cyc));
    t1_per = 2;
    dbl = 1'b1;
    for (int s = 0; s < 4; s++) begin
      rsrc = 2'(s);
      wr(aspc_pkg::ADDR_STATUS, {3'b000, dbl, 2'b00, rsrc});
      rx_case(8'hd0, 8'($random(seed)), 1'($random(seed)), 1'b1);
    end
    saddr = 8'h35;
    smask = 8'h0f;
    wr(aspc_pkg::ADDR_SADDR, saddr);
    wr(aspc_pkg::ADDR_SMASK, smask);
    rd_chk(aspc_pkg::ADDR_SADDR, 8'h35, 8'hff, "saddr");
    rd_chk(aspc_pkg::ADDR_SMASK, 8'h0f, 8'hff, "smask");
    foreach (rcase[i]) begin
      rx_case(rcase[i][17:10], rcase[i][9:2], rcase[i][1], rcase[i][0]);
    end
    d = 8'($random(seed));
    wr(aspc_pkg::ADDR_CONTROL, 8'hd0);
    st.nine    = 1'b1;
    st.bit_cyc = bit_len(2'b11, dbl, rsrc);
    st.send(~d, 1'b0, 1'b1);
    st.send(d, 1'b0, 1'b1);
    rd_chk(aspc_pkg::ADDR_STATUS, 8'h40, 8'h40, "overrun");
    rd_chk(aspc_pkg::ADDR_BUFFER, d, 8'hff, "rx data");
    give_verdict();
  end
endmodule : aspc_uart_test
`default_nettype wire
